// [logic/rbf_ctrl.sv]
/*
  Reference buffer control and conversion result formatter.
  Assumes core samples arrive on the core clock with a valid pulse,
  and that analog switch controls are sampled by the analog front end.
*/
`timescale 1ns/10ps
`default_nettype none

module rbf_ctrl
  import rbf_pkg::*;
(
  input  wire logic        core_clk_i,        // Core clock, 100 MHz
  input  wire logic        rst_b_i,           // Async reset, active low
  input  wire logic [7:0]  reg_addr_i,        // Register byte address
  input  wire logic [31:0] reg_wdata_i,       // Register write data
  input  wire logic        reg_wr_i,          // Write strobe
  input  wire logic        reg_rd_i,          // Read strobe
  output logic      [31:0] reg_rdata_o,       // Read data, next cycle
  input  wire logic        sample_valid_i,    // Core sample strobe
  input  wire logic [2:0]  sample_chan_i,     // Core sample channel
  input  wire logic [15:0] sample_data_i,     // Core sample, binary
  output logic             result_valid_o,    // Result pulse
  output logic      [2:0]  result_chan_o,     // Result channel
  output logic      [18:0] result_data_o,     // Result, sign extended if bipolar, zero extended if unipolar
  output logic      [4:0]  result_width_o,    // Result width in bits
  output logic             ref_buffer_on_o,   // Buffer power
  output logic             bypass_switch_o,   // Bypass switch closed
  output logic             ref_isolate_o,     // Node cut from outside
  output logic             ref_buffer_high_current_o, // Boost active
  output logic             ref_input_low_load_o       // Low-load input
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] osr_last(input logic [1:0] code);
    unique case (rbf_osr_t'(code))
      RBF_OSR_1:  osr_last = 6'h00;
      RBF_OSR_4:  osr_last = 6'h03;
      RBF_OSR_16: osr_last = 6'h0F;
      RBF_OSR_64: osr_last = 6'h3F;
    endcase
  endfunction

  function automatic logic [4:0] res_width(input logic [1:0] code);
    res_width = 5'(RBF_CORE_W) + {3'h0, code};
  endfunction

  // Addresses below the bank base wrap high and so miss the bank
  function automatic logic bank_hit(input logic [7:0] addr,
                                    input logic [7:0] base);
    logic [7:0] offs;
    offs     = addr - base;
    bank_hit = offs[7:5] == 3'h0 && offs[1:0] == 2'h0;
  endfunction

  function automatic logic [2:0] bank_chan(input logic [7:0] addr,
                                           input logic [7:0] base);
    logic [7:0] offs;
    offs      = addr - base;
    bank_chan = offs[4:2];
  endfunction

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [3:0]  ref_ctrl_q;
  logic [2:0]  chan_cfg_q  [RBF_CHANNELS];
  logic [15:0] offset_q    [RBF_CHANNELS];
  logic [15:0] gain_q      [RBF_CHANNELS];
  logic        cfg_sel;
  logic        corr_sel;
  logic [2:0]  cfg_chan;
  logic [2:0]  corr_chan;

  assign cfg_sel   = bank_hit(reg_addr_i, RBF_CHAN_CFG_BASE);
  assign corr_sel  = bank_hit(reg_addr_i, RBF_CHAN_CORR_BASE);
  assign cfg_chan  = bank_chan(reg_addr_i, RBF_CHAN_CFG_BASE);
  assign corr_chan = bank_chan(reg_addr_i, RBF_CHAN_CORR_BASE);

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ref_ctrl_q <= RBF_REF_CONTROL_RST;
    else if (reg_wr_i && reg_addr_i == RBF_REF_CONTROL_ADDR)
      ref_ctrl_q <= reg_wdata_i[3:0];
  end

  genvar g;
  generate
    for (g = 0; g < RBF_CHANNELS; g++)
    begin : g_chan_regs
      always_ff @(posedge core_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          chan_cfg_q[g] <= RBF_CHAN_CFG_RST;
          offset_q[g]   <= RBF_OFFSET_RST;
          gain_q[g]     <= RBF_GAIN_RST;
        end
        else if (reg_wr_i)
        begin
          if (cfg_sel && cfg_chan == 3'(g))
            chan_cfg_q[g] <= reg_wdata_i[2:0];
          if (corr_sel && corr_chan == 3'(g))
          begin
            offset_q[g] <= reg_wdata_i[15:0];
            gain_q[g]   <= reg_wdata_i[RBF_GAIN_LSB +: 16];
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Reference buffer switch control
  // ---------------------------------------------------------------
  // Registered so the analog switches never see decode glitches.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ref_buffer_on_o           <= 1'b0;
      bypass_switch_o           <= 1'b0;
      ref_isolate_o             <= 1'b0;
      ref_buffer_high_current_o <= 1'b0;
      ref_input_low_load_o      <= 1'b0;
    end
    else
    begin
      ref_buffer_on_o      <= ref_ctrl_q[RBF_BUF_ON_BIT];
      // Enable wins: the switch never shorts the driven node
      bypass_switch_o      <= ref_ctrl_q[RBF_BYPASS_BIT]
                              && !ref_ctrl_q[RBF_BUF_ON_BIT];
      ref_isolate_o        <= ref_ctrl_q[RBF_BUF_ON_BIT];
      ref_buffer_high_current_o <= ref_ctrl_q[RBF_HI_CUR_BIT]
                              && ref_ctrl_q[RBF_BUF_ON_BIT];
      ref_input_low_load_o <= ref_ctrl_q[RBF_LOW_LOAD_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Oversampling accumulators
  // ---------------------------------------------------------------
  logic [RBF_ACC_W-1:0] acc_q [RBF_CHANNELS];
  logic [RBF_CNT_W-1:0] cnt_q [RBF_CHANNELS];
  logic [RBF_ACC_W-1:0] acc_sum;
  logic [1:0]           in_osr;
  logic                 in_last;

  assign in_osr  = chan_cfg_q[sample_chan_i][1:0];
  assign acc_sum = acc_q[sample_chan_i]
                   + {{(RBF_ACC_W-RBF_CORE_W){1'b0}}, sample_data_i};
  assign in_last = cnt_q[sample_chan_i] >= osr_last(in_osr);

  generate
    for (g = 0; g < RBF_CHANNELS; g++)
    begin : g_acc
      always_ff @(posedge core_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          acc_q[g] <= '0;
          cnt_q[g] <= '0;
        end
        else if (sample_valid_i && sample_chan_i == 3'(g))
        begin
          if (in_last)
          begin
            acc_q[g] <= '0;
            cnt_q[g] <= '0;
          end
          else
          begin
            acc_q[g] <= acc_sum;
            cnt_q[g] <= cnt_q[g] + 6'h01;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Decimation stage
  // ---------------------------------------------------------------
  // Sum of 4^k samples shifted by k keeps k extra bits of resolution.
  logic                 dec_valid_q;
  logic [2:0]           dec_chan_q;
  logic [1:0]           dec_osr_q;
  logic [RBF_RESULT_W-1:0] dec_raw_q;

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dec_valid_q <= 1'b0;
      dec_chan_q  <= 3'h0;
      dec_osr_q   <= 2'h0;
      dec_raw_q   <= '0;
    end
    else
    begin
      dec_valid_q <= sample_valid_i && in_last;
      if (sample_valid_i && in_last)
      begin
        dec_chan_q <= sample_chan_i;
        dec_osr_q  <= in_osr;
        dec_raw_q  <= RBF_RESULT_W'(acc_sum >> in_osr);
      end
    end
  end

  // ---------------------------------------------------------------
  // Polarity, offset and gain correction
  // ---------------------------------------------------------------
  logic signed [23:0] corr_val;
  logic signed [23:0] lim_max;
  logic signed [23:0] lim_min;
  logic signed [23:0] corr_sat;

  always_comb
  begin
    logic [4:0]          width;
    logic                bipolar;
    logic [23:0]         msb;
    logic signed [23:0]  code;
    logic signed [40:0]  prod;
    logic signed [23:0]  offs;
    width    = res_width(dec_osr_q);
    bipolar  = chan_cfg_q[dec_chan_q][RBF_POLARITY_BIT];
    msb      = 24'h000001 << (width - 5'h01);
    code     = signed'({5'h00, dec_raw_q});
    // Top bit inverted and read signed equals removing half scale
    if (bipolar)
      code   = signed'({5'h00, dec_raw_q}) - signed'(msb);
    prod     = code * signed'({1'b0, gain_q[dec_chan_q]});
    offs     = signed'({{8{offset_q[dec_chan_q][15]}},
                       offset_q[dec_chan_q]}) <<< dec_osr_q;
    corr_val = signed'(prod[RBF_GAIN_FRAC +: 24]) + offs;
    lim_max  = bipolar ? signed'(msb - 24'h000001)
                       : signed'((msb << 1) - 24'h000001);
    lim_min  = bipolar ? -signed'(msb) : 24'sh000000;
    if (corr_val > lim_max)
      corr_sat = lim_max;
    else if (corr_val < lim_min)
      corr_sat = lim_min;
    else
      corr_sat = corr_val;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      result_valid_o <= 1'b0;
      result_chan_o  <= 3'h0;
      result_data_o  <= '0;
      result_width_o <= 5'(RBF_CORE_W);
    end
    else
    begin
      result_valid_o <= dec_valid_q;
      if (dec_valid_q)
      begin
        result_chan_o  <= dec_chan_q;
        result_data_o  <= corr_sat[RBF_RESULT_W-1:0];
        result_width_o <= res_width(dec_osr_q);
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  // Data stands only in the cycle after the strobe; zero otherwise.
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (reg_addr_i == RBF_REF_CONTROL_ADDR)
      rd_mux = {28'h0, ref_ctrl_q};
    else if (reg_addr_i == RBF_REF_STATUS_ADDR)
      rd_mux = {27'h0, ref_input_low_load_o, ref_buffer_high_current_o,
                ref_isolate_o, bypass_switch_o, ref_buffer_on_o};
    else if (reg_addr_i == RBF_LAST_RESULT_ADDR)
      rd_mux = {5'h0, result_chan_o, 5'h0, result_data_o};
    else if (cfg_sel)
      rd_mux = {29'h0, chan_cfg_q[cfg_chan]};
    else if (corr_sel)
      rd_mux = {gain_q[corr_chan], offset_q[corr_chan]};
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= 32'h0000_0000;
    else
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
  end

endmodule

`default_nettype wire

// [logic/rbf_pkg.sv]
/*
  Constants for the reference buffer control and result formatting block:
  register offsets, field positions, reset values and result widths.
  Assumes a 100 MHz core clock and a plain strobe register port.
*/
`default_nettype none

package rbf_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] RBF_REF_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] RBF_REF_STATUS_ADDR  = 8'h04;
  localparam logic [7:0] RBF_LAST_RESULT_ADDR = 8'h08;
  localparam logic [7:0] RBF_CHAN_CFG_BASE    = 8'h10;
  localparam logic [7:0] RBF_CHAN_CORR_BASE   = 8'h30;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int RBF_BUF_ON_BIT    = 0;
  localparam int RBF_BYPASS_BIT    = 1;
  localparam int RBF_HI_CUR_BIT    = 2;
  localparam int RBF_LOW_LOAD_BIT  = 3;
  localparam int RBF_ISOLATE_BIT   = 2;
  localparam int RBF_POLARITY_BIT  = 2;
  localparam int RBF_CHAN_FLD_LSB  = 24;
  localparam int RBF_GAIN_LSB      = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  RBF_REF_CONTROL_RST = 4'h0;
  localparam logic [2:0]  RBF_CHAN_CFG_RST    = 3'h0;
  localparam logic [15:0] RBF_OFFSET_RST      = 16'h0000;
  localparam logic [15:0] RBF_GAIN_RST        = 16'h8000;

  // ---------------------------------------------------------------
  // Result formatting
  // ---------------------------------------------------------------
  localparam int RBF_CHANNELS   = 8;
  localparam int RBF_CORE_W     = 16;
  localparam int RBF_RESULT_W   = 19;
  localparam int RBF_ACC_W      = 22;
  localparam int RBF_CNT_W      = 6;
  localparam int RBF_GAIN_FRAC  = 15;

  typedef enum logic [1:0] {
    RBF_OSR_1  = 2'h0,
    RBF_OSR_4  = 2'h1,
    RBF_OSR_16 = 2'h2,
    RBF_OSR_64 = 2'h3
  } rbf_osr_t;

endpackage

`default_nettype wire

// [sim/rbf_host_model.sv]
/* Host model for the rbf_ctrl register port.
   Assumes the core clock is shared; strobes last one cycle. */
`timescale 1ns/10ps
`default_nettype none
module rbf_host_model
  import rbf_pkg::*;
(
  input  wire logic        core_clk_i,  // Clock
  input  wire logic [31:0] reg_rdata_i, // Read data
  output var  logic [7:0]  reg_addr_o,  // Address
  output var  logic [31:0] reg_wdata_o, // Write data
  output var  logic        reg_wr_o,    // Write strobe
  output var  logic        reg_rd_o     // Read strobe
);
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 32'h0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Idle lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
  endtask
  // Low-load input always set together with the buffer
  task automatic ref_ctl(input logic en, bp, bst);
    wr(RBF_REF_CONTROL_ADDR, {28'h0, en, bst, bp, en});
  endtask
endmodule
`default_nettype wire

// [sim/rbf_ctrl_monitor.sv]
/* Port checker for rbf_ctrl, bound into the design.
   Assumes one core clock and an async active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module rbf_ctrl_monitor
  import rbf_pkg::*;
(
  input wire logic        core_clk_i,                // Clock
  input wire logic        rst_b_i,                   // Reset
  input wire logic [7:0]  reg_addr_i,                // Address
  input wire logic [31:0] reg_wdata_i,               // Write data
  input wire logic        reg_wr_i,                  // Write strobe
  input wire logic        sample_valid_i,            // Sample strobe
  input wire logic        result_valid_o,            // Result pulse
  input wire logic [4:0]  result_width_o,            // Result width
  input wire logic        ref_buffer_on_o,           // Buffer power
  input wire logic        bypass_switch_o,           // Switch closed
  input wire logic        ref_isolate_o,             // Node isolated
  input wire logic        ref_buffer_high_current_o  // Boost
);
  logic ctl_wr;
  assign ctl_wr = reg_wr_i && reg_addr_i == RBF_REF_CONTROL_ADDR;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_bypass_close: assert property (ctl_wr && reg_wdata_i[1:0] == 2'h2
    |-> ##2 bypass_switch_o && !ref_buffer_on_o) else $error("bypass");
  a_buffer_drive: assert property (ctl_wr && reg_wdata_i[0]
    |-> ##2 ref_buffer_on_o && !bypass_switch_o) else $error("drive");
  a_node_isolate: assert property (ref_isolate_o == ref_buffer_on_o)
    else $error("isolate");
  a_boost_gated: assert property (ref_buffer_high_current_o
    |-> ref_buffer_on_o) else $error("boost gate");
  a_boost_set: assert property (ctl_wr && reg_wdata_i[2] && reg_wdata_i[0]
    |-> ##2 ref_buffer_high_current_o) else $error("boost");
  a_reset_off: assert property ($rose(rst_b_i)
    |-> !ref_buffer_on_o && !bypass_switch_o) else $error("reset");
  a_result_cause: assert property (result_valid_o
    |-> $past(sample_valid_i, 2)) else $error("result cause");
  a_width_range: assert property (result_valid_o
    |-> result_width_o inside {[5'h10:5'h13]}) else $error("width");
  a_width_hold: assert property (!result_valid_o
    |-> $stable(result_width_o)) else $error("width hold");
  c_bypass: cover property (ctl_wr ##2 bypass_switch_o);
  c_boost: cover property (ref_buffer_high_current_o);
  c_wide: cover property (result_valid_o && result_width_o == 5'h13);
endmodule
bind rbf_ctrl rbf_ctrl_monitor rbf_ctrl_monitor_i (.core_clk_i, .rst_b_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .sample_valid_i, .result_valid_o,
  .result_width_o, .ref_buffer_on_o, .bypass_switch_o, .ref_isolate_o,
  .ref_buffer_high_current_o);
`default_nettype wire

// [sim/rbf_ctrl_tb_top.sv]
/* Self-checking bench for rbf_ctrl: reference control and results.
   Assumes the host model drives the register port. */
`timescale 1ns/10ps
`default_nettype none
module rbf_ctrl_tb_top;
  import rbf_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sv = 1'b0;
  logic [2:0]  sch = 3'h0;
  logic [15:0] sd = 16'h0000;
  logic [7:0]  addr;
  logic [31:0] wdat, rdat, rv32;
  logic        wr, rd, rv, on, byp, iso, hc, ll;
  logic [2:0]  rch;
  logic [18:0] res;
  logic [4:0]  rw;
  int          bad_count = 0;
  int          check_count = 0;
  always #5 clk = ~clk;
  rbf_ctrl rbf_ctrl_i (.core_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
    .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .sample_valid_i(sv), .sample_chan_i(sch), .sample_data_i(sd),
    .result_valid_o(rv), .result_chan_o(rch), .result_data_o(res),
    .result_width_o(rw), .ref_buffer_on_o(on), .bypass_switch_o(byp),
    .ref_isolate_o(iso), .ref_buffer_high_current_o(hc),
    .ref_input_low_load_o(ll));
  rbf_host_model host_i (.core_clk_i(clk), .reg_rdata_i(rdat),
    .reg_addr_o(addr), .reg_wdata_o(wdat), .reg_wr_o(wr), .reg_rd_o(rd));
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ctl(input logic en, bp, bst);
    host_i.ref_ctl(en, bp, bst);
    repeat (2) @(posedge clk);
    #1;
    chk({on, byp, iso, hc, ll}, {en, bp & ~en, en, bst & en, en});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    host_i.rd(a, rv32);
    chk(rv32, exp);
  endtask
  // Samples go to channel 2; the result is awaited with a bound
  task automatic snd(input logic [15:0] d, input int n,
                     input logic [18:0] ed, input logic [4:0] ew);
    int k;
    repeat (n)
    begin
      @(posedge clk);
      sv <= 1'b1;
      sch <= 3'h2;
      sd <= d;
    end
    @(posedge clk);
    sv <= 1'b0;
    sd <= ~d;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (rv !== 1'b1 && k < 8);
    chk({rv, rch, rw, 4'h0, res}, {1'b1, 3'h2, ew, 4'h0, ed});
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    chk({on, byp, iso, hc, ll, rv, rw}, {6'h00, 5'h10});
    host_i.wr(8'hFC, 32'hFFFFFFFF);
    rchk(RBF_REF_CONTROL_ADDR, 32'h0);
    rchk(RBF_CHAN_CORR_BASE + 8'h08, 32'h80000000);
    ctl(1'b0, 1'b1, 1'b0);
    host_i.wr(RBF_CHAN_CORR_BASE + 8'h08, 32'h80000005);
    ctl(1'b1, 1'b0, 1'b1);
    rchk(RBF_REF_CONTROL_ADDR, 32'h0000000D);
    ctl(1'b0, 1'b1, 1'b1);
    ctl(1'b1, 1'b1, 1'b0);
    rchk(RBF_REF_STATUS_ADDR, 32'h00000015);
    rchk(RBF_CHAN_CFG_BASE, 32'h00000000);
    snd(16'h1000, 1, 19'h01005, 5'h10);
    host_i.wr(RBF_CHAN_CORR_BASE + 8'h08, 32'h40000000);
    snd(16'h1000, 1, 19'h00800, 5'h10);
    host_i.wr(RBF_CHAN_CORR_BASE + 8'h08, 32'h80000000);
    for (int k = 0; k < 4; k++)
    begin
      host_i.wr(RBF_CHAN_CFG_BASE + 8'h08, 32'(k));
      snd(16'h1234, 4 ** k, 19'h01234 << k, 5'h10 + 5'(k));
    end
    host_i.wr(RBF_CHAN_CFG_BASE + 8'h08, 32'h00000004);
    rchk(RBF_CHAN_CFG_BASE + 8'h08, 32'h00000004);
    snd(16'h0000, 1, 19'h78000, 5'h10);
    snd(16'hFFFF, 1, 19'h07FFF, 5'h10);
    rchk(RBF_LAST_RESULT_ADDR, {5'h0, 3'h2, 5'h0, 19'h07FFF});
    give_verdict();
  end
  initial
  begin
    #100000;
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
